// ---- ires_raw_status.sv ----
`default_nettype none
module ires_raw_status
  import ires_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_out,
  output logic o_scl_oe,
  input wire logic i_fsm_active,
  input wire logic i_general_call_seen_ack,
  input wire logic i_rx_byte_valid,
  input wire logic [DATA_W-1:0] i_rx_byte,
  input wire logic i_slv_tx_nack,
  input wire logic i_tx_abort_evt,
  input wire logic [15:0] i_abort_cause,
  input wire logic i_rd_req_evt,
  output logic o_tx_valid,
  output logic [DATA_W-1:0] o_tx_data,
  input wire logic i_tx_pop,
  output logic o_controller_enabled,
  output logic o_intr
);
  localparam int LVL_W = $clog2(DEPTH + 1);
  localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(DEPTH);

  typedef struct packed {
    logic en;
    logic controller_enabled;
    logic [NUM_FLAGS-1:0] mask;
    logic [TL_W-1:0] rx_tl;
    logic [TL_W-1:0] tx_tl;
    logic general_call_seen;
    logic start;
    logic stop;
    logic activity;
    logic rx_done;
    logic tx_abort;
    logic rd_req;
    logic tx_over;
    logic rx_over;
    logic rx_under;
    logic [15:0] cause;
    logic [31:0] prdata;
  } ires_state_type;

  ires_state_type state_ff;
  ires_state_type nxt_state;
  logic start_pulse;
  logic stop_pulse;
  logic rd_acc;
  logic wr_acc;
  logic rd_setup;
  logic clr_all;
  logic tx_push;
  logic tx_ready;
  logic rx_push;
  logic rx_ready;
  logic rx_valid;
  logic rx_pop;
  logic [DATA_W-1:0] rx_data;
  logic [LVL_W-1:0] tx_level;
  logic [LVL_W-1:0] rx_level;
  logic [15:0] raw;
  logic [15:0] masked;

  function automatic logic [TL_W-1:0] sat_tl(input logic [31:0] v);
    return (v > 32'(TL_MAX)) ? TL_MAX : v[TL_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  ires_cond_detect u_detect (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_start(start_pulse),
    .o_stop(stop_pulse)
  );

  ires_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_flush(!state_ff.en || state_ff.tx_abort),
    .i_wr_valid(tx_push),
    .o_wr_ready(tx_ready),
    .i_wr_data(i_pwdata[DATA_W-1:0]),
    .o_rd_valid(o_tx_valid),
    .i_rd_ready(i_tx_pop),
    .o_rd_data(o_tx_data),
    .o_level(tx_level)
  );

  ires_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_flush(!state_ff.en),
    .i_wr_valid(rx_push),
    .o_wr_ready(rx_ready),
    .i_wr_data(i_rx_byte),
    .o_rd_valid(rx_valid),
    .i_rd_ready(rx_pop),
    .o_rd_data(rx_data),
    .o_level(rx_level)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    raw = '0;
    raw[BIT_GENERAL_CALL_SEEN] = state_ff.general_call_seen;
    raw[BIT_START] = state_ff.start;
    raw[BIT_STOP] = state_ff.stop;
    raw[BIT_ACTIVITY] = state_ff.activity;
    raw[BIT_RX_DONE] = state_ff.rx_done;
    raw[BIT_TX_ABORT] = state_ff.tx_abort;
    raw[BIT_RD_REQ] = state_ff.rd_req;
    // level flags follow the fifos, no storage of their own
    raw[BIT_TX_EMPTY] = state_ff.controller_enabled && (tx_level <= {1'b0, state_ff.tx_tl});
    raw[BIT_TX_OVER] = state_ff.tx_over;
    raw[BIT_RX_FULL] = state_ff.en && (rx_level >= ({1'b0, state_ff.rx_tl} + 1'b1));
    raw[BIT_RX_OVER] = state_ff.rx_over;
    raw[BIT_RX_UNDER] = state_ff.rx_under;
    masked = raw & {4'h0, state_ff.mask};
  end

  assign rd_acc = i_psel && i_penable && !i_pwrite;
  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign rd_setup = i_psel && !i_penable && !i_pwrite;
  assign clr_all = rd_acc && (i_paddr == ADDR_CLR_ALL);
  // writes during abort or disable fall on a flushed fifo and are lost
  assign tx_push = wr_acc && (i_paddr == ADDR_DATA_CMD);
  assign rx_push = i_rx_byte_valid && state_ff.en;
  assign rx_pop = rd_acc && (i_paddr == ADDR_DATA_CMD);
  assign o_prdata = state_ff.prdata;
  assign o_pready = 1'b1;
  assign o_scl_out = 1'b0;
  assign o_scl_oe = state_ff.rd_req;
  assign o_controller_enabled = state_ff.en;
  assign o_intr = |masked;

  always_comb begin
    nxt_state = state_ff;
    // internal enable lingers until the bus machines finish
    nxt_state.controller_enabled = state_ff.en || (state_ff.controller_enabled && i_fsm_active);
    if (wr_acc) begin
      case (i_paddr)
        ADDR_ENABLE: nxt_state.en = i_pwdata[0];
        ADDR_INTR_MASK: nxt_state.mask = i_pwdata[NUM_FLAGS-1:0];
        ADDR_RX_TL: nxt_state.rx_tl = sat_tl(i_pwdata);
        ADDR_TX_TL: nxt_state.tx_tl = sat_tl(i_pwdata);
        default: nxt_state.en = state_ff.en;
      endcase
    end
    if (rd_setup) begin
      case (i_paddr)
        ADDR_DATA_CMD: nxt_state.prdata = {24'h000000, rx_data};
        ADDR_INTR_STAT: nxt_state.prdata = {16'h0000, masked};
        ADDR_INTR_MASK: nxt_state.prdata = {20'h00000, state_ff.mask};
        ADDR_RAW_STATUS: nxt_state.prdata = {16'h0000, raw};
        ADDR_RX_TL: nxt_state.prdata = {27'h0000000, state_ff.rx_tl};
        ADDR_TX_TL: nxt_state.prdata = {27'h0000000, state_ff.tx_tl};
        ADDR_ENABLE: nxt_state.prdata = {31'h00000000, state_ff.en};
        ADDR_ABORT_CAUSE: nxt_state.prdata = {16'h0000, state_ff.cause};
        default: nxt_state.prdata = 32'h00000000;
      endcase
    end
    // in every flag below a set in the same cycle beats a clear
    if (state_ff.en && i_general_call_seen_ack) begin
      nxt_state.general_call_seen = 1'b1;
    end else if (!state_ff.en || clr_all || (rd_acc && i_paddr == ADDR_CLR_GENERAL_CALL_SEEN)) begin
      nxt_state.general_call_seen = 1'b0;
    end
    if (start_pulse) begin
      nxt_state.start = 1'b1;
    end else if (clr_all) begin
      nxt_state.start = 1'b0;
    end
    if (stop_pulse) begin
      nxt_state.stop = 1'b1;
    end else if (clr_all) begin
      nxt_state.stop = 1'b0;
    end
    if (state_ff.en && (i_fsm_active || start_pulse)) begin
      nxt_state.activity = 1'b1;
    end else if (!state_ff.en || clr_all || (rd_acc && i_paddr == ADDR_CLR_ACTIVITY)) begin
      nxt_state.activity = 1'b0;
    end
    if (i_slv_tx_nack) begin
      nxt_state.rx_done = 1'b1;
    end else if (clr_all) begin
      nxt_state.rx_done = 1'b0;
    end
    if (i_tx_abort_evt) begin
      nxt_state.tx_abort = 1'b1;
      nxt_state.cause = i_abort_cause;
    end else begin
      if (clr_all || (rd_acc && i_paddr == ADDR_CLR_TX_ABORT)) begin
        nxt_state.tx_abort = 1'b0;
      end
      if (clr_all) begin
        nxt_state.cause = 16'h0000;
      end
    end
    if (i_rd_req_evt) begin
      nxt_state.rd_req = 1'b1;
    end else if (clr_all || (rd_acc && i_paddr == ADDR_CLR_RD_REQ)) begin
      nxt_state.rd_req = 1'b0;
    end
    if (tx_push && tx_level == FULL_LVL) begin
      nxt_state.tx_over = 1'b1;
    end else if (!state_ff.controller_enabled || clr_all || (rd_acc && i_paddr == ADDR_CLR_TX_OVER)) begin
      nxt_state.tx_over = 1'b0;
    end
    if (rx_push && !rx_ready) begin
      nxt_state.rx_over = 1'b1;
    end else if (!state_ff.controller_enabled || clr_all || (rd_acc && i_paddr == ADDR_CLR_RX_OVER)) begin
      nxt_state.rx_over = 1'b0;
    end
    if (rx_pop && !rx_valid) begin
      nxt_state.rx_under = 1'b1;
    end else if (!state_ff.controller_enabled || clr_all || (rd_acc && i_paddr == ADDR_CLR_RX_UNDER)) begin
      nxt_state.rx_under = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= '0;
      state_ff.mask <= MASK_RESET;
      state_ff.rx_tl <= TL_RESET;
      state_ff.tx_tl <= TL_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);

  property p_general_call_seen_set;
    state_ff.en && i_general_call_seen_ack |=> raw[BIT_GENERAL_CALL_SEEN];
  endproperty
  a_general_call_seen_set: assert property (p_general_call_seen_set) else $error("general call flag not set");

  property p_general_call_seen_drop;
    !state_ff.en && !i_general_call_seen_ack |=> !raw[BIT_GENERAL_CALL_SEEN];
  endproperty
  a_general_call_seen_drop: assert property (p_general_call_seen_drop) else $error("general call flag kept while off");

  property p_stretch;
    i_rd_req_evt |=> o_scl_oe && !o_scl_out;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock not held during read request");

  property p_rd_req_clear;
    rd_acc && i_paddr == ADDR_CLR_RD_REQ && !i_rd_req_evt |=> !raw[BIT_RD_REQ] && !o_scl_oe;
  endproperty
  a_rd_req_clear: assert property (p_rd_req_clear) else $error("read request not cleared");

  // a pop or a flush in the same cycle may lower the level; the extra byte still must not land
  property p_tx_over;
    wr_acc && i_paddr == ADDR_DATA_CMD && tx_level == FULL_LVL |=>
      raw[BIT_TX_OVER] && (tx_level == FULL_LVL || $past(i_tx_pop) || !$past(o_tx_valid));
  endproperty
  a_tx_over: assert property (p_tx_over) else $error("transmit overflow missed");

  property p_rx_over;
    rx_push && rx_level == FULL_LVL && !rx_pop |=> raw[BIT_RX_OVER] && $stable(rx_level);
  endproperty
  a_rx_over: assert property (p_rx_over) else $error("receive overflow missed or byte kept");

  property p_rx_flush;
    $fell(state_ff.en) |-> !raw[BIT_RX_FULL] ##1 rx_level == '0;
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("receive fifo not flushed");

  property p_abort_flush;
    state_ff.tx_abort |=> tx_level == '0 && !o_tx_valid;
  endproperty
  a_abort_flush: assert property (p_abort_flush) else $error("transmit fifo not held empty");

  property p_under;
    rx_pop && !rx_valid |=> raw[BIT_RX_UNDER];
  endproperty
  a_under: assert property (p_under) else $error("receive underflow missed");

  property p_reserved;
    raw[15:12] == 4'h0 && o_prdata[31:16] == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_activity_hold;
    raw[BIT_ACTIVITY] && state_ff.en && !clr_all && !(rd_acc && i_paddr == ADDR_CLR_ACTIVITY) |=> raw[BIT_ACTIVITY];
  endproperty
  a_activity_hold: assert property (p_activity_hold) else $error("activity flag lost");
endmodule
`default_nettype wire

// ---- ires_pkg.sv ----
`default_nettype none
package ires_pkg;
  localparam logic [31:0] ADDR_DATA_CMD = 32'h50001310;
  localparam logic [31:0] ADDR_INTR_STAT = 32'h5000132C;
  localparam logic [31:0] ADDR_INTR_MASK = 32'h50001330;
  localparam logic [31:0] ADDR_RAW_STATUS = 32'h50001334;
  localparam logic [31:0] ADDR_RX_TL = 32'h50001338;
  localparam logic [31:0] ADDR_TX_TL = 32'h5000133C;
  localparam logic [31:0] ADDR_CLR_ALL = 32'h50001340;
  localparam logic [31:0] ADDR_CLR_RX_UNDER = 32'h50001344;
  localparam logic [31:0] ADDR_CLR_RX_OVER = 32'h50001348;
  localparam logic [31:0] ADDR_CLR_TX_OVER = 32'h5000134C;
  localparam logic [31:0] ADDR_CLR_RD_REQ = 32'h50001350;
  localparam logic [31:0] ADDR_CLR_TX_ABORT = 32'h50001354;
  localparam logic [31:0] ADDR_CLR_ACTIVITY = 32'h5000135C;
  localparam logic [31:0] ADDR_CLR_GENERAL_CALL_SEEN = 32'h50001368;
  localparam logic [31:0] ADDR_ENABLE = 32'h5000136C;
  localparam logic [31:0] ADDR_ABORT_CAUSE = 32'h50001380;
  localparam int BIT_GENERAL_CALL_SEEN = 11;
  localparam int BIT_START = 10;
  localparam int BIT_STOP = 9;
  localparam int BIT_ACTIVITY = 8;
  localparam int BIT_RX_DONE = 7;
  localparam int BIT_TX_ABORT = 6;
  localparam int BIT_RD_REQ = 5;
  localparam int BIT_TX_EMPTY = 4;
  localparam int BIT_TX_OVER = 3;
  localparam int BIT_RX_FULL = 2;
  localparam int BIT_RX_OVER = 1;
  localparam int BIT_RX_UNDER = 0;
  localparam int NUM_FLAGS = 12;
  localparam int FIFO_DEPTH = 32;
  localparam int DATA_W = 8;
  localparam int TL_W = 5;
  localparam logic [TL_W-1:0] TL_MAX = 5'h1F;
  localparam logic [NUM_FLAGS-1:0] MASK_RESET = 12'h8FF;
  localparam logic [TL_W-1:0] TL_RESET = 5'h00;
endpackage
`default_nettype wire

// ---- ires_fifo.sv ----
`default_nettype none
module ires_fifo
  import ires_pkg::*;
#(
  parameter int W = DATA_W,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int LVL_W = $clog2(DEPTH + 1)
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_flush,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [W-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [W-1:0] o_rd_data,
  output logic [LVL_W-1:0] o_level
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [LVL_W-1:0] cnt;
  } ires_fifo_state_type;

  ires_fifo_state_type state_ff;
  ires_fifo_state_type nxt_state;
  logic push;
  logic pop;

  assign o_wr_ready = (state_ff.cnt != FULL_LVL) && !i_flush;
  assign o_rd_valid = (state_ff.cnt != '0) && !i_flush;
  assign o_rd_data = state_ff.mem[state_ff.rptr];
  assign o_level = state_ff.cnt;

  always_comb begin
    nxt_state = state_ff;
    push = i_wr_valid && o_wr_ready;
    pop = i_rd_ready && o_rd_valid;
    if (i_flush) begin
      // pointers and count only; stale data still shows on o_rd_data, with o_rd_valid low at cnt zero
      nxt_state.wptr = '0;
      nxt_state.rptr = '0;
      nxt_state.cnt = '0;
    end else begin
      if (push) begin
        nxt_state.mem[state_ff.wptr] = i_wr_data;
        nxt_state.wptr = state_ff.wptr + 1'b1;
      end
      if (pop) begin
        nxt_state.rptr = state_ff.rptr + 1'b1;
      end
      if (push && !pop) begin
        nxt_state.cnt = state_ff.cnt + 1'b1;
      end else if (pop && !push) begin
        nxt_state.cnt = state_ff.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end
endmodule
`default_nettype wire

// ---- ires_cond_detect.sv ----
`default_nettype none
module ires_cond_detect (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_start,
  output logic o_stop
);
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    logic start;
    logic stop;
  } ires_det_state_type;

  ires_det_state_type state_ff;
  ires_det_state_type nxt_state;

  assign o_start = state_ff.start;
  assign o_stop = state_ff.stop;

  always_comb begin
    nxt_state = state_ff;
    // first stage feeds only the second stage
    nxt_state.scl_sync = {state_ff.scl_sync[0], i_scl};
    nxt_state.sda_sync = {state_ff.sda_sync[0], i_sda};
    nxt_state.scl_prev = state_ff.scl_sync[1];
    nxt_state.sda_prev = state_ff.sda_sync[1];
    // sda edge while scl stays high
    nxt_state.start = state_ff.scl_sync[1] && state_ff.scl_prev && state_ff.sda_prev && !state_ff.sda_sync[1];
    nxt_state.stop = state_ff.scl_sync[1] && state_ff.scl_prev && !state_ff.sda_prev && state_ff.sda_sync[1];
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      // idle bus is high on both lines
      state_ff <= 8'hF0;
    end else begin
      state_ff <= nxt_state;
    end
  end
endmodule
`default_nettype wire

// ---- ires_bus_partner.sv ----
`default_nettype none
module ires_bus_partner (
  input wire logic i_go,
  output logic o_scl,
  output logic o_sda,
  output logic o_done
);
  timeunit 1ns;
  timeprecision 100ps;
  // half of the 125 ns link clock; scl stands high between frames
  localparam realtime HALF = 62.5;

  task automatic clocks();
    repeat (4) begin
      #HALF o_scl = 1'b0;
      #HALF o_scl = 1'b1;
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // one process owns the lines: idle levels, then one frame per request
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    o_done = 1'b0;
    // frame: start, clocks, repeated start, clocks, stop
    forever begin
      @(posedge i_go);
      o_done = 1'b0;
      #HALF o_sda = 1'b0;
      clocks();
      // sda rises only while scl is low, else it would be a false stop
      #HALF o_scl = 1'b0;
      #HALF o_sda = 1'b1;
      #HALF o_scl = 1'b1;
      #HALF o_sda = 1'b0;
      clocks();
      #HALF o_scl = 1'b0;
      #HALF o_scl = 1'b1;
      #HALF o_sda = 1'b1;
      o_done = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- ires_raw_status_test.sv ----
`default_nettype none
module ires_raw_status_test
  import ires_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic i_core_clk, i_reset_n, psel, penable, pwrite, fsm_active, gc_ack, rx_v, nack, abrt, rdq, pop, go;
  logic [31:0] paddr, pwdata, prdata, v;
  logic [7:0] rx_b, tx_data;
  logic [15:0] cause;
  logic pready, scl_oe, scl_out, tx_valid, enabled, intr, p_scl, p_sda, p_done;
  wire scl_w;
  int fails, num_checks, i;

  // open-drain clock line: either party may pull it low
  assign scl_w = p_scl & (~scl_oe | scl_out);

  ires_raw_status i_dut (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .i_scl(scl_w), .i_sda(p_sda), .o_scl_out(scl_out), .o_scl_oe(scl_oe), .i_fsm_active(fsm_active),
    .i_general_call_seen_ack(gc_ack), .i_rx_byte_valid(rx_v), .i_rx_byte(rx_b), .i_slv_tx_nack(nack),
    .i_tx_abort_evt(abrt), .i_abort_cause(cause), .i_rd_req_evt(rdq), .o_tx_valid(tx_valid),
    .o_tx_data(tx_data), .i_tx_pop(pop), .o_controller_enabled(enabled), .o_intr(intr)
  );

  ires_bus_partner i_partner (.i_go(go), .o_scl(p_scl), .o_sda(p_sda), .o_done(p_done));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // setup then access; answer taken at the access edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(negedge i_core_clk);
    psel = 1'b1;
    penable = 1'b0;
    pwrite = w;
    paddr = a;
    pwdata = d;
    @(negedge i_core_clk);
    penable = 1'b1;
    // wait states, if any, stretch the access phase
    @(posedge i_core_clk);
    while (pready !== 1'b1) @(posedge i_core_clk);
    r = prdata;
    @(negedge i_core_clk);
    psel = 1'b0;
    penable = 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, r);
  endtask

  // activity bit left out: its source lies in the bus machines
  task automatic raw(input logic [31:0] e);
    logic [31:0] r;
    rd(ADDR_RAW_STATUS, r);
    chk(r & 32'hFFFFFEFF, e);
  endtask

  task automatic evt(input int k);
    @(negedge i_core_clk);
    case (k)
      0: gc_ack = 1'b1;
      1: nack = 1'b1;
      2: abrt = 1'b1;
      3: rdq = 1'b1;
      4: rx_v = 1'b1;
      default: pop = 1'b1;
    endcase
    @(negedge i_core_clk);
    {gc_ack, nack, abrt, rdq, rx_v, pop} = 6'h0;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end

  initial begin
    {i_reset_n, psel, penable, pwrite, fsm_active, gc_ack, rx_v, nack, abrt, rdq, pop, go} = 12'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    rx_b = 8'h0;
    cause = 16'h00A5;
    fails = 0;
    num_checks = 0;
    repeat (6) @(negedge i_core_clk);
    i_reset_n = 1'b1;
    rd(ADDR_RAW_STATUS, v);
    chk(v, 32'h0);
    chk(32'(intr), 32'h0);
    wr(ADDR_ENABLE, 32'h1);
    chk(32'(enabled), 32'h1);
    raw(32'h010);
    chk(32'(intr), 32'h1);
    rd(ADDR_INTR_STAT, v);
    chk(v, 32'h010);
    wr(ADDR_INTR_MASK, 32'h0);
    chk(32'(intr), 32'h0);
    evt(0);
    raw(32'h810);
    rx_b = 8'hC3;
    evt(4);
    raw(32'h814);
    rd(ADDR_DATA_CMD, v);
    chk(v, 32'hC3);
    rd(ADDR_DATA_CMD, v);
    raw(32'h811);
    rd(ADDR_CLR_GENERAL_CALL_SEEN, v);
    raw(32'h011);
    evt(1);
    raw(32'h091);
    evt(3);
    raw(32'h0B1);
    chk(32'(scl_w), 32'h0);
    chk(32'(scl_out), 32'h0);
    wr(ADDR_DATA_CMD, 32'h5A);
    raw(32'h0A1);
    chk({23'h0, tx_valid, tx_data}, 32'h15A);
    rd(ADDR_CLR_RD_REQ, v);
    raw(32'h081);
    chk(32'(scl_oe), 32'h0);
    evt(5);
    raw(32'h091);
    for (i = 0; i < 33; i++) begin
      wr(ADDR_DATA_CMD, 32'(i));
    end
    raw(32'h089);
    wr(ADDR_TX_TL, 32'h1F);
    evt(5);
    raw(32'h099);
    evt(2);
    raw(32'h0D9);
    rd(ADDR_ABORT_CAUSE, v);
    chk(v, 32'hA5);
    wr(ADDR_DATA_CMD, 32'h77);
    chk(32'(tx_valid), 32'h0);
    rd(ADDR_CLR_TX_ABORT, v);
    wr(ADDR_DATA_CMD, 32'h77);
    chk({23'h0, tx_valid, tx_data}, 32'h177);
    raw(32'h099);
    wr(ADDR_RX_TL, 32'h28);
    rd(ADDR_RX_TL, v);
    chk(v, 32'h1F);
    for (i = 0; i < 33; i++) begin
      rx_b = 8'h40 + 8'(i);
      evt(4);
    end
    raw(32'h09F);
    rd(ADDR_DATA_CMD, v);
    chk(v, 32'h40);
    raw(32'h09B);
    rd(ADDR_CLR_RX_UNDER, v);
    rd(ADDR_CLR_RX_OVER, v);
    rd(ADDR_CLR_TX_OVER, v);
    raw(32'h090);
    @(negedge i_core_clk);
    go = 1'b1;
    repeat (400) if (!p_done) @(negedge i_core_clk);
    go = 1'b0;
    repeat (6) @(negedge i_core_clk);
    raw(32'h690);
    rd(ADDR_RAW_STATUS, v);
    chk(v, 32'h790);
    rd(ADDR_CLR_ACTIVITY, v);
    rd(ADDR_RAW_STATUS, v);
    chk(v, 32'h690);
    fsm_active = 1'b1;
    rd(ADDR_CLR_ALL, v);
    raw(32'h010);
    rd(ADDR_ABORT_CAUSE, v);
    chk(v, 32'h0);
    for (i = 0; i < 32; i++) begin
      wr(ADDR_DATA_CMD, 32'h11);
    end
    repeat (2) evt(4);
    raw(32'h00E);
    wr(ADDR_ENABLE, 32'h0);
    raw(32'h01A);
    fsm_active = 1'b0;
    repeat (3) @(negedge i_core_clk);
    rd(ADDR_RAW_STATUS, v);
    chk(v, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
